// File: design/adpc_top.sv
// Purpose: Address and data pin behaviour control with APB registers
// Assumes: All inputs synchronous to ref_clk; one cycle class at a time
// Notes:   Pin outputs are registered, one ref_clk behind their inputs
//
// Notes on behaviour
// - ROM1 A20: mapper or latched address
// - A20 ROM1 select resets cleared
// - DRAM A[19:12]: mapper or latched address
// - I/O A[19:16]: low or latched address
// - Idle data: float or hold last
// - Pin control registers at indices 15H and 16H
// - Reserved bits read zero, no effect
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

module adpc_top
  import adpc_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  // Bus cycle status from the core
  input  wire logic          cyc_rom1,
  input  wire logic          cyc_dram,
  input  wire logic          cyc_io,
  input  wire logic          cyc_done,
  input  wire logic          stop_mode,
  input  wire logic [20:12]  core_addr,
  input  wire logic [15:0]   core_data,
  input  wire logic          core_data_oe,
  // Pins
  output logic [20:12]       pin_addr,
  output logic [15:0]        pin_data_o,
  output logic               pin_data_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Register access

  logic a20_rom1_latch_select_q;
  logic upper_addr_dram_latch_select_q;
  logic io_upper_addr_latch_select_q;
  logic stop_mode_data_clamp_enable_q;
  logic idle_data_bus_hold_enable_q;
  logic [20:12] addr_latch_q;
  logic [20:12] addr_d;
  logic [15:0]  last_data_q;
  logic [15:0]  data_d;
  logic         data_oe_d;
  logic         wr_en;
  logic         hit2;
  logic         hit3;
  adpc_cyc_t    cyc;

  function automatic logic addr_hit(input logic [AW-1:0] a, input logic [7:0] b);
    addr_hit = (a == AW'(b));
  endfunction

  assign hit2    = addr_hit(paddr, ADPC_ADDR_PIN_CTRL2);
  assign hit3    = addr_hit(paddr, ADPC_ADDR_PIN_CTRL3);
  assign pready  = clk_en;
  assign pslverr = psel && penable && !(hit2 || hit3);
  assign wr_en   = clk_en && psel && penable && pwrite && pstrb[0];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      a20_rom1_latch_select_q <= ADPC_SEL_RST;
    end else if (wr_en && hit2) begin
      a20_rom1_latch_select_q <= pwdata[ADPC_A20_ROM1_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      upper_addr_dram_latch_select_q <= ADPC_SEL_RST;
      io_upper_addr_latch_select_q   <= ADPC_SEL_RST;
      stop_mode_data_clamp_enable_q  <= ADPC_SEL_RST;
      idle_data_bus_hold_enable_q    <= ADPC_SEL_RST;
    end else if (wr_en && hit3) begin
      upper_addr_dram_latch_select_q <= pwdata[ADPC_DRAM_BIT];
      io_upper_addr_latch_select_q   <= pwdata[ADPC_IO_BIT];
      stop_mode_data_clamp_enable_q  <= pwdata[ADPC_CLAMP_BIT];
      idle_data_bus_hold_enable_q    <= pwdata[ADPC_HOLD_BIT];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (hit2) begin
      prdata[ADPC_A20_ROM1_BIT] = a20_rom1_latch_select_q;
    end else if (hit3) begin
      prdata[ADPC_DRAM_BIT]  = upper_addr_dram_latch_select_q;
      prdata[ADPC_IO_BIT]    = io_upper_addr_latch_select_q;
      prdata[ADPC_CLAMP_BIT] = stop_mode_data_clamp_enable_q;
      prdata[ADPC_HOLD_BIT]  = idle_data_bus_hold_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address pins

  always_comb begin
    if (cyc_rom1) begin
      cyc = ADPC_CYC_ROM1;
    end else if (cyc_dram) begin
      cyc = ADPC_CYC_DRAM;
    end else if (cyc_io) begin
      cyc = ADPC_CYC_IO;
    end else begin
      cyc = ADPC_CYC_OTHER;
    end
  end

  always_comb begin
    addr_d = core_addr;
    case (cyc)
      ADPC_CYC_ROM1: begin
        addr_d[20] = a20_rom1_latch_select_q ? addr_latch_q[20] : core_addr[20];
      end
      ADPC_CYC_DRAM: begin
        if (upper_addr_dram_latch_select_q) begin
          addr_d[19:12] = addr_latch_q[19:12];
        end
      end
      ADPC_CYC_IO: begin
        addr_d[19:16] = io_upper_addr_latch_select_q ? addr_latch_q[19:16] : 4'h0;
      end
      default: begin
        addr_d = core_addr;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_addr <= ADPC_ADDR_RST;
    end else if (clk_en) begin
      pin_addr <= addr_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_latch_q <= ADPC_ADDR_RST;
    end else if (clk_en && cyc_done) begin
      addr_latch_q <= pin_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data pins

  always_comb begin
    data_d    = last_data_q;
    data_oe_d = 1'b0;
    if (core_data_oe) begin
      data_d    = core_data;
      data_oe_d = 1'b1;
    end else if (stop_mode) begin
      data_d    = ADPC_DATA_RST;
      data_oe_d = stop_mode_data_clamp_enable_q;
    end else begin
      data_oe_d = idle_data_bus_hold_enable_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      last_data_q <= ADPC_DATA_RST;
    end else if (clk_en && core_data_oe) begin
      last_data_q <= core_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_data_o  <= ADPC_DATA_RST;
      pin_data_oe <= 1'b0;
    end else if (clk_en) begin
      pin_data_o  <= data_d;
      pin_data_oe <= data_oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  rom1_a20_map_a: assert property (
    clk_en && cyc_rom1 && !a20_rom1_latch_select_q |=> pin_addr[20] == $past(core_addr[20])
  ) else $error("A20 did not follow mapper in ROM1 cycle");

  rom1_a20_hold_a: assert property (
    clk_en && cyc_rom1 && a20_rom1_latch_select_q |=> pin_addr[20] == $past(addr_latch_q[20])
  ) else $error("A20 did not hold latch in ROM1 cycle");

  sel_reset_a: assert property (
    $past(sys_rst) |-> !a20_rom1_latch_select_q && prdata[7:0] == 8'h00
  ) else $error("Select bits not cleared after reset");

  dram_upper_a: assert property (
    clk_en && cyc_dram && !cyc_rom1 |=> pin_addr[19:12] ==
      ($past(upper_addr_dram_latch_select_q) ? $past(addr_latch_q[19:12]) : $past(core_addr[19:12]))
  ) else $error("A[19:12] wrong in DRAM cycle");

  io_upper_a: assert property (
    clk_en && cyc_io && !cyc_rom1 && !cyc_dram |=> pin_addr[19:16] ==
      ($past(io_upper_addr_latch_select_q) ? $past(addr_latch_q[19:16]) : 4'h0)
  ) else $error("A[19:16] wrong in I/O cycle");

  stop_clamp_a: assert property (
    clk_en && stop_mode && !core_data_oe |=>
      pin_data_oe == $past(stop_mode_data_clamp_enable_q) && pin_data_o == 16'h0000
  ) else $error("Data pins wrong in stop mode");

  idle_hold_a: assert property (
    clk_en && !stop_mode && !core_data_oe && idle_data_bus_hold_enable_q ##1
      clk_en && !stop_mode && !core_data_oe |=>
      pin_data_oe == $past(idle_data_bus_hold_enable_q) && $stable(pin_data_o)
  ) else $error("Data not held in idle cycles");

  reg_rdback_a: assert property (
    wr_en && hit3 |=> hit3 |-> prdata[7:0] == ($past(pwdata[7:0]) & 8'hcc)
  ) else $error("Control register read back wrong");

  rsvd_zero_a: assert property (
    psel && hit3 |-> prdata[5:4] == 2'b00 && prdata[1:0] == 2'b00 && prdata[31:8] == 24'h0
  ) else $error("Reserved bits not zero");

  latch_upd_a: assert property (
    clk_en && cyc_done |=> addr_latch_q == $past(pin_addr)
  ) else $error("Address latch not updated");

  rom1_low_a: assert property (
    clk_en && cyc_rom1 |=> pin_addr[19:12] == $past(core_addr[19:12])
  ) else $error("A[19:12] did not follow mapper in ROM1 cycle");

  dram_a20_a: assert property (
    clk_en && cyc_dram && !cyc_rom1 |=> pin_addr[20] == $past(core_addr[20])
  ) else $error("A20 wrong in DRAM cycle");

  io_low_a: assert property (
    clk_en && cyc_io && !cyc_rom1 && !cyc_dram |=> pin_addr[15:12] == $past(core_addr[15:12]) &&
      pin_addr[20] == $past(core_addr[20])
  ) else $error("A[15:12] or A20 wrong in I/O cycle");

  idle_float_a: assert property (
    clk_en && !stop_mode && !core_data_oe && !idle_data_bus_hold_enable_q |=> !pin_data_oe
  ) else $error("Data pins driven in idle cycle with hold off");

  core_drive_a: assert property (
    clk_en && core_data_oe |=> pin_data_oe && pin_data_o == $past(core_data)
  ) else $error("Data pins did not carry core data");

  unmapped_err_a: assert property (
    psel && penable && !hit2 && !hit3 |-> pslverr && prdata == 32'h0000_0000
  ) else $error("Unmapped access not refused");

  strb_block_a: assert property (
    clk_en && psel && penable && pwrite && !pstrb[0] |=>
      $stable(upper_addr_dram_latch_select_q) && $stable(idle_data_bus_hold_enable_q) &&
      $stable(a20_rom1_latch_select_q)
  ) else $error("Write without byte strobe changed a register");

  freeze_a: assert property (
    !clk_en |=> $stable(pin_addr) && $stable(pin_data_o) && $stable(pin_data_oe) && $stable(addr_latch_q)
  ) else $error("State changed while clock enable low");

  pins_reset_a: assert property (
    $past(sys_rst) |-> pin_addr == ADPC_ADDR_RST && !pin_data_oe && addr_latch_q == ADPC_ADDR_RST
  ) else $error("Pins not at reset state after reset");

  stall_c:       cover property (psel && penable && !pready);
  rom1_hold_c:   cover property (cyc_rom1 && a20_rom1_latch_select_q);
  dram_hold_c:   cover property (cyc_dram && upper_addr_dram_latch_select_q ##1 cyc_done);
  stop_clamp_c:  cover property (stop_mode && stop_mode_data_clamp_enable_q ##1 pin_data_oe);
  idle_hold_c:   cover property (idle_data_bus_hold_enable_q && !core_data_oe ##2 pin_data_oe);

endmodule

// File: design/adpc_pkg.sv
// Purpose: Constants for the address and data pin control block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register indices are scaled by four into byte addresses
package adpc_pkg;

  // Register indices and byte addresses
  localparam logic [7:0] ADPC_IDX_PIN_CTRL2 = 8'h15;
  localparam logic [7:0] ADPC_IDX_PIN_CTRL3 = 8'h16;
  localparam logic [7:0] ADPC_ADDR_PIN_CTRL2 = 8'(ADPC_IDX_PIN_CTRL2 * 4);
  localparam logic [7:0] ADPC_ADDR_PIN_CTRL3 = 8'(ADPC_IDX_PIN_CTRL3 * 4);

  // Field positions in pin control register 2
  localparam int ADPC_A20_ROM1_BIT = 1;

  // Field positions in pin control register 3
  localparam int ADPC_DRAM_BIT  = 7;
  localparam int ADPC_IO_BIT    = 6;
  localparam int ADPC_CLAMP_BIT = 3;
  localparam int ADPC_HOLD_BIT  = 2;

  // Reset values
  localparam logic       ADPC_SEL_RST  = 1'b0;
  localparam logic [8:0] ADPC_ADDR_RST = 9'h000;
  localparam logic [15:0] ADPC_DATA_RST = 16'h0000;

  // Cycle class seen at the pins
  typedef enum logic [1:0] {
    ADPC_CYC_OTHER,
    ADPC_CYC_ROM1,
    ADPC_CYC_DRAM,
    ADPC_CYC_IO
  } adpc_cyc_t;

endpackage

// File: tb/adpc_bus_dev.sv
// Purpose: Far-side device on the data pins
// Assumes: No pull resistor on the data lines
// Notes:   A released line shows the inverse of its last value
`timescale 1ns/1ps
module adpc_bus_dev (
  // Pins
  input  wire logic        ref_clk,
  input  wire logic [15:0] pin_data_o,
  input  wire logic        pin_data_oe,
  output logic      [15:0] bus_d
);
  logic [15:0] last_q;
  always_ff @(posedge ref_clk) begin
    if (pin_data_oe) begin
      last_q <= pin_data_o;
    end
  end
  assign bus_d = pin_data_oe ? pin_data_o : ~last_q;
endmodule

// File: tb/address_data_pin_control_test.sv
// Purpose: Self-checking bench of the pin control block
// Assumes: APB waits while clock enable is low, pins one edge behind inputs
// Notes:   Two passes, all selects clear then all set
`timescale 1ns/1ps
module address_data_pin_control_test;
  import adpc_pkg::*;
  logic        ref_clk = 0, sys_rst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rs = 32'h3916;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, cyc_rom1 = 0, cyc_dram = 0, cyc_io = 0, cyc_done = 0;
  logic        stop_mode = 0, core_data_oe = 0, pin_data_oe, pin_chk = 0;
  logic [20:12] core_addr = 9'h000, pin_addr;
  logic [15:0] core_data = 16'h0, pin_data_o, bus_d, d;
  logic [8:0]  l, b;
  logic [31:0] qr[$];
  logic [63:0] qp[$];
  logic [63:0] e;
  int          err_total = 0, num_checks = 0;

  adpc_top adpc_top_i (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .pstrb        (pstrb),
    .pready       (pready),
    .prdata       (prdata),
    .pslverr      (pslverr),
    .cyc_rom1     (cyc_rom1),
    .cyc_dram     (cyc_dram),
    .cyc_io       (cyc_io),
    .cyc_done     (cyc_done),
    .stop_mode    (stop_mode),
    .core_addr    (core_addr),
    .core_data    (core_data),
    .core_data_oe (core_data_oe),
    .pin_addr     (pin_addr),
    .pin_data_o   (pin_data_o),
    .pin_data_oe  (pin_data_oe)
  );
  adpc_bus_dev adpc_bus_dev_i (
    .ref_clk     (ref_clk),
    .pin_data_o  (pin_data_o),
    .pin_data_oe (pin_data_oe),
    .bus_d       (bus_d)
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [31:0] x);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w) begin
      qr.push_back(x);
    end
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask

  // Class bits are rom1, dram, io, stop; result is oe, data, address
  task automatic pin(input logic [3:0] cls, input logic [31:0] m, input logic [31:0] x);
    {cyc_rom1, cyc_dram, cyc_io, stop_mode} <= cls;
    @(posedge ref_clk);
    qp.push_back({m, x});
    pin_chk <= 1;
    @(posedge ref_clk);
    pin_chk <= 0;
  endtask

  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite) begin
      chk_reg({pslverr, prdata[30:0]}, qr.pop_front());
    end
    if (pin_chk) begin
      e = qp.pop_front();
      chk_pin({pin_data_oe, bus_d, 6'h00, pin_addr} & e[63:32], e[31:0]);
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    apb(0, ADPC_ADDR_PIN_CTRL2, 0, 32'h0);
    apb(0, ADPC_ADDR_PIN_CTRL3, 0, 32'h0);
    apb(0, 8'h10, 0, 32'h80000000);
    pstrb <= 4'he;
    apb(1, ADPC_ADDR_PIN_CTRL3, 32'hcc, 0);
    pstrb <= 4'hf;
    clk_en <= 0;
    fork
      apb(0, ADPC_ADDR_PIN_CTRL3, 0, 32'h0);
      begin
        repeat (3) @(posedge ref_clk);
        clk_en <= 1;
      end
    join
    $display("strobe and stall test done");
    for (int s = 0; s < 2; s++) begin
      apb(1, ADPC_ADDR_PIN_CTRL2, s ? 32'hff : 32'hfd, 0);
      apb(1, ADPC_ADDR_PIN_CTRL3, s ? 32'hff : 32'h33, 0);
      apb(0, ADPC_ADDR_PIN_CTRL2, 0, s ? 32'h2 : 32'h0);
      apb(0, ADPC_ADDR_PIN_CTRL3, 0, s ? 32'hcc : 32'h0);
      l = 9'(rnd());
      b = 9'(rnd());
      d = 16'(rnd());
      core_addr <= l;
      repeat (2) @(posedge ref_clk);
      cyc_done <= 1;
      @(posedge ref_clk);
      cyc_done <= 0;
      core_addr <= b;
      pin(4'b1000, 32'h1ff, s ? {l[8], b[7:0]} : b);
      pin(4'b0100, 32'h1ff, s ? {b[8], l[7:0]} : b);
      pin(4'b0010, 32'h1ff, {b[8], s ? l[7:4] : 4'h0, b[3:0]});
      core_data_oe <= 1;
      core_data <= d;
      pin(0, 32'hffff8000, {1'b1, d, 15'h0});
      core_data_oe <= 0;
      pin(0, s ? 32'hffff8000 : 32'h80000000, s ? {1'b1, d, 15'h0} : 32'h0);
      pin(4'b0001, s ? 32'hffff8000 : 32'h80000000, {s[0], 31'h0});
      $display("pass %0d done", s);
    end
    sys_rst <= 1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 0;
    @(posedge ref_clk);
    apb(0, ADPC_ADDR_PIN_CTRL2, 0, 32'h0);
    apb(0, ADPC_ADDR_PIN_CTRL3, 0, 32'h0);
    $display("reset test done");
    conclude();
  end

  initial begin
    #(50 * 2000);
    err_total++;
    conclude();
  end
endmodule
